// ### hw/pmcf_counter.sv
`timescale 1ns/1ps
module pmcf_counter #(
  parameter int WIDTH = 64
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             inc,
  input  wire logic             wr_lo,
  input  wire logic             wr_hi,
  input  wire logic [31:0]      wr_data,
  // Value
  output logic      [WIDTH-1:0] value
);
  import pmcf_pkg::*;

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // Software write beats the increment in the same cycle
  always_comb
  begin
    count_d = count_q;
    if (wr_lo)
    begin
      count_d[31:0] = wr_data;
    end
    else if (wr_hi)
    begin
      count_d[WIDTH-1:32] = wr_data[WIDTH-33:0];
    end
    else if (inc)
    begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_q <= COUNT_RESET[WIDTH-1:0];
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign value = count_q;

endmodule : pmcf_counter

// ### hw/pmcf_filter.sv
`timescale 1ns/1ps
// What this block does
// - Two 64-bit filter configuration registers: one for cycles, one for retirements.
// - Bit 63, the overflow flag position, always reads zero.
// - Bit 62 set stops counting while in machine mode.
// - Bit 61 set stops counting in supervisor or hypervisor-extended supervisor mode.
// - Bit 60 set stops counting in user mode.
// - Bit 59 set stops counting in virtual supervisor mode.
// - Bit 58 set stops counting in virtual user mode.
// - All inhibit bits clear means counting in every mode.
// - Inhibit bits of unimplemented modes are hardwired zero.
// - On 32-bit harts, upper halves reachable through separate high-half registers.
// - Full registers decode at CSR numbers 0x321 and 0x322.
// - High-half registers decode at CSR numbers 0x721 and 0x722.
// - No counter advances while in a mode marked inhibited.
// - Cycles counted only in non-inhibited modes; trap cycle attribution is free.
// - Retirements counted only when retiring in a non-inhibited mode.
// - Instructions raising a synchronous exception upward do not count.
// - Trap returns count only when their originating mode is not inhibited.
module pmcf_filter
  import pmcf_pkg::*;
#(
  parameter int XLEN          = 64,
  parameter bit HAS_SUPER     = 1'b1,
  parameter bit HAS_USER      = 1'b1,
  parameter bit HAS_HYPER     = 1'b1
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // CSR port from the hart
  input  wire logic                  csr_we,
  input  wire logic [11:0]           csr_addr,
  input  wire logic [XLEN-1:0]       csr_wdata,
  output logic      [XLEN-1:0]       csr_rdata,
  output logic                       csr_hit,
  // Pipeline events
  input  wire pmcf_pkg::pmcf_mode_type cur_mode,
  input  wire logic                  retire_valid,
  input  wire logic                  retire_exception,
  input  wire pmcf_pkg::pmcf_mode_type retire_mode,
  // Counter write port
  input  wire logic                  cnt_we_cycle_lo,
  input  wire logic                  cnt_we_cycle_hi,
  input  wire logic                  cnt_we_retire_lo,
  input  wire logic                  cnt_we_retire_hi,
  input  wire logic [31:0]           cnt_wdata,
  // Counter values
  output logic      [63:0]           cycle_count,
  output logic      [63:0]           retire_count
);

  // ----------------------------------------
  // Configuration storage
  // ----------------------------------------
  logic [63:0] cycle_cfg_q;
  logic [63:0] cycle_cfg_d;
  logic [63:0] retire_cfg_q;
  logic [63:0] retire_cfg_d;
  logic [63:0] wmask;
  logic [63:0] wr_full;

  // Writable bit mask; unimplemented modes and overflow flag stay zero
  always_comb
  begin
    wmask                     = 64'hFFFF_FFFF_FFFF_FFFF;
    wmask[OVERFLOW_FLAG_BIT]  = 1'b0;
    wmask[SUPERVISOR_INH_BIT] = HAS_SUPER;
    wmask[USER_INH_BIT]       = HAS_USER;
    wmask[VIRT_SUPER_INH_BIT] = HAS_HYPER;
    wmask[VIRT_USER_INH_BIT]  = HAS_HYPER & HAS_USER;
  end

  always_comb
  begin
    wr_full = 64'h0000_0000_0000_0000;
    wr_full[XLEN-1:0] = csr_wdata;
  end

  // Reserved low bits are stored as written
  always_comb
  begin
    cycle_cfg_d  = cycle_cfg_q;
    retire_cfg_d = retire_cfg_q;
    if (csr_we)
    begin
      if (csr_addr == CSR_CYCLE_CFG)
      begin
        if (XLEN == 64)
        begin
          cycle_cfg_d = wr_full & wmask;
        end
        else
        begin
          cycle_cfg_d[31:0] = wr_full[31:0];
        end
      end
      else if (csr_addr == CSR_RETIRE_CFG)
      begin
        if (XLEN == 64)
        begin
          retire_cfg_d = wr_full & wmask;
        end
        else
        begin
          retire_cfg_d[31:0] = wr_full[31:0];
        end
      end
      else if (csr_addr == CSR_CYCLE_CFG_H && XLEN == 32)
      begin
        cycle_cfg_d[63:32] = wr_full[31:0] & wmask[63:32];
      end
      else if (csr_addr == CSR_RETIRE_CFG_H && XLEN == 32)
      begin
        retire_cfg_d[63:32] = wr_full[31:0] & wmask[63:32];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cycle_cfg_q  <= CFG_RESET;
      retire_cfg_q <= CFG_RESET;
    end
    else
    begin
      cycle_cfg_q  <= cycle_cfg_d;
      retire_cfg_q <= retire_cfg_d;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [XLEN-1:0] rdata_d;
  logic [XLEN-1:0] rdata_q;
  logic            hit_d;
  logic            hit_q;

  always_comb
  begin
    rdata_d = '0;
    hit_d   = 1'b1;
    if (csr_addr == CSR_CYCLE_CFG)
    begin
      rdata_d = cycle_cfg_q[XLEN-1:0];
    end
    else if (csr_addr == CSR_RETIRE_CFG)
    begin
      rdata_d = retire_cfg_q[XLEN-1:0];
    end
    else if (csr_addr == CSR_CYCLE_CFG_H && XLEN == 32)
    begin
      rdata_d = cycle_cfg_q[63:64-XLEN];
    end
    else if (csr_addr == CSR_RETIRE_CFG_H && XLEN == 32)
    begin
      rdata_d = retire_cfg_q[63:64-XLEN];
    end
    else
    begin
      hit_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= '0;
      hit_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  assign csr_rdata = rdata_q;
  assign csr_hit   = hit_q;

  // ----------------------------------------
  // Inhibit fields
  // ----------------------------------------
  logic cyc_machine_count_inhibit;
  logic cyc_supervisor_count_inhibit;
  logic cyc_user_count_inhibit;
  logic cyc_virtual_supervisor_count_inhibit;
  logic cyc_virtual_user_count_inhibit;
  logic ret_machine_count_inhibit;
  logic ret_supervisor_count_inhibit;
  logic ret_user_count_inhibit;
  logic ret_virtual_supervisor_count_inhibit;
  logic ret_virtual_user_count_inhibit;

  // Unimplemented modes read back zero, so their fields never inhibit
  always_comb
  begin
    cyc_machine_count_inhibit            = cycle_cfg_q[MACHINE_INH_BIT];
    cyc_supervisor_count_inhibit         = cycle_cfg_q[SUPERVISOR_INH_BIT];
    cyc_user_count_inhibit               = cycle_cfg_q[USER_INH_BIT];
    cyc_virtual_supervisor_count_inhibit = cycle_cfg_q[VIRT_SUPER_INH_BIT];
    cyc_virtual_user_count_inhibit       = cycle_cfg_q[VIRT_USER_INH_BIT];
    ret_machine_count_inhibit            = retire_cfg_q[MACHINE_INH_BIT];
    ret_supervisor_count_inhibit         = retire_cfg_q[SUPERVISOR_INH_BIT];
    ret_user_count_inhibit               = retire_cfg_q[USER_INH_BIT];
    ret_virtual_supervisor_count_inhibit = retire_cfg_q[VIRT_SUPER_INH_BIT];
    ret_virtual_user_count_inhibit       = retire_cfg_q[VIRT_USER_INH_BIT];
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic cur_machine;
  logic cur_supervisor;
  logic cur_user;
  logic cur_virtual_supervisor;
  logic cur_virtual_user;
  logic ret_machine;
  logic ret_supervisor;
  logic ret_user;
  logic ret_virtual_supervisor;
  logic ret_virtual_user;

  // Current mode; an unused code matches no level and is never inhibited
  always_comb
  begin
    cur_machine            = 1'b0;
    cur_supervisor         = 1'b0;
    cur_user               = 1'b0;
    cur_virtual_supervisor = 1'b0;
    cur_virtual_user       = 1'b0;
    case (cur_mode)
      PMCF_MODE_MACHINE:    cur_machine            = 1'b1;
      PMCF_MODE_SUPERVISOR: cur_supervisor         = 1'b1;
      PMCF_MODE_USER:       cur_user               = 1'b1;
      PMCF_MODE_VIRT_SUPER: cur_virtual_supervisor = 1'b1;
      PMCF_MODE_VIRT_USER:  cur_virtual_user       = 1'b1;
      default:              cur_machine            = 1'b0;
    endcase
  end

  // Mode the instruction executed from, so a trap return uses its origin
  always_comb
  begin
    ret_machine            = 1'b0;
    ret_supervisor         = 1'b0;
    ret_user               = 1'b0;
    ret_virtual_supervisor = 1'b0;
    ret_virtual_user       = 1'b0;
    case (retire_mode)
      PMCF_MODE_MACHINE:    ret_machine            = 1'b1;
      PMCF_MODE_SUPERVISOR: ret_supervisor         = 1'b1;
      PMCF_MODE_USER:       ret_user               = 1'b1;
      PMCF_MODE_VIRT_SUPER: ret_virtual_supervisor = 1'b1;
      PMCF_MODE_VIRT_USER:  ret_virtual_user       = 1'b1;
      default:              ret_machine            = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Mode filter
  // ----------------------------------------
  logic cycle_inh;
  logic retire_inh;
  logic cycle_inc;
  logic retire_inc;

  // Mode changes during a trap take effect whenever cur_mode switches
  always_comb
  begin
    cycle_inh  = (cur_machine & cyc_machine_count_inhibit)
               | (cur_supervisor & cyc_supervisor_count_inhibit)
               | (cur_user & cyc_user_count_inhibit)
               | (cur_virtual_supervisor & cyc_virtual_supervisor_count_inhibit)
               | (cur_virtual_user & cyc_virtual_user_count_inhibit);
    retire_inh = (ret_machine & ret_machine_count_inhibit)
               | (ret_supervisor & ret_supervisor_count_inhibit)
               | (ret_user & ret_user_count_inhibit)
               | (ret_virtual_supervisor & ret_virtual_supervisor_count_inhibit)
               | (ret_virtual_user & ret_virtual_user_count_inhibit);
    cycle_inc  = !cycle_inh;
    retire_inc = retire_valid && !retire_exception && !retire_inh;
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  pmcf_counter #(
    .WIDTH   (64)
  ) u_cycle (
    .clk     (clk),
    .nrst    (nrst),
    .inc     (cycle_inc),
    .wr_lo   (cnt_we_cycle_lo),
    .wr_hi   (cnt_we_cycle_hi),
    .wr_data (cnt_wdata),
    .value   (cycle_count)
  );

  pmcf_counter #(
    .WIDTH   (64)
  ) u_retire (
    .clk     (clk),
    .nrst    (nrst),
    .inc     (retire_inc),
    .wr_lo   (cnt_we_retire_lo),
    .wr_hi   (cnt_we_retire_hi),
    .wr_data (cnt_wdata),
    .value   (retire_count)
  );

endmodule : pmcf_filter

// ### hw/pmcf_pkg.sv
package pmcf_pkg;

  // ----------------------------------------
  // CSR numbers
  // ----------------------------------------
  localparam logic [11:0] CSR_CYCLE_CFG    = 12'h321;
  localparam logic [11:0] CSR_RETIRE_CFG   = 12'h322;
  localparam logic [11:0] CSR_CYCLE_CFG_H  = 12'h721;
  localparam logic [11:0] CSR_RETIRE_CFG_H = 12'h722;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OVERFLOW_FLAG_BIT   = 63;
  localparam int MACHINE_INH_BIT     = 62;
  localparam int SUPERVISOR_INH_BIT  = 61;
  localparam int USER_INH_BIT        = 60;
  localparam int VIRT_SUPER_INH_BIT  = 59;
  localparam int VIRT_USER_INH_BIT   = 58;
  localparam int RESERVED_TOP_BIT    = 57;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [63:0] CFG_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] COUNT_RESET = 64'h0000_0000_0000_0000;

  // ----------------------------------------
  // Privilege modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PMCF_MODE_USER,
    PMCF_MODE_SUPERVISOR,
    PMCF_MODE_MACHINE,
    PMCF_MODE_VIRT_SUPER,
    PMCF_MODE_VIRT_USER
  } pmcf_mode_type;

endpackage : pmcf_pkg

// ### tb/pmcf_filter_props.sv
`timescale 1ns/1ps
module pmcf_filter_props
  import pmcf_pkg::*;
#(
  parameter int XLEN = 64
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // CSR port
  input wire logic              csr_we,
  input wire logic [11:0]       csr_addr,
  input wire logic [XLEN-1:0]   csr_wdata,
  input wire logic [XLEN-1:0]   csr_rdata,
  input wire logic              csr_hit,
  // Pipeline and counters
  input wire pmcf_pkg::pmcf_mode_type cur_mode,
  input wire logic              retire_valid,
  input wire logic              retire_exception,
  input wire pmcf_pkg::pmcf_mode_type retire_mode,
  input wire logic              cnt_we_cycle_lo,
  input wire logic              cnt_we_cycle_hi,
  input wire logic              cnt_we_retire_lo,
  input wire logic              cnt_we_retire_hi,
  input wire logic [63:0]       cycle_count,
  input wire logic [63:0]       retire_count
);
  logic [4:0] cyc_d, cyc_q, ret_d, ret_q;
  logic       cw, rw, live_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !live_q);
  // Off for the release edge itself: counters still sit in reset there
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) live_q <= 1'b0;
    else live_q <= 1'b1;
  end
  // Shadow of inhibit bits 62:58, updated on the same edge as the device
  always_comb
  begin
    cyc_d = cyc_q;
    ret_d = ret_q;
    if (csr_we && csr_addr == CSR_CYCLE_CFG) cyc_d = csr_wdata[62:58];
    if (csr_we && csr_addr == CSR_RETIRE_CFG) ret_d = csr_wdata[62:58];
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) {cyc_q, ret_q} <= '0;
    else {cyc_q, ret_q} <= {cyc_d, ret_d};
  end
  // Software loads override counting
  assign cw = cnt_we_cycle_lo | cnt_we_cycle_hi;
  assign rw = cnt_we_retire_lo | cnt_we_retire_hi;
  function automatic logic inh(logic [4:0] c, pmcf_mode_type m);
    case (m)
      PMCF_MODE_MACHINE:    return c[4];
      PMCF_MODE_SUPERVISOR: return c[3];
      PMCF_MODE_USER:       return c[2];
      PMCF_MODE_VIRT_SUPER: return c[1];
      default:              return c[0];
    endcase
  endfunction : inh
  sequence s_ret_wr;
    csr_we && csr_addr == CSR_RETIRE_CFG;
  endsequence
  sequence s_ret_rd;
    !csr_we && csr_addr == CSR_RETIRE_CFG;
  endsequence
  AST_CYC_HIT: assert property (csr_addr == CSR_CYCLE_CFG |=> csr_hit) else $error("cycle cfg miss");
  AST_RET_HIT: assert property (csr_addr == CSR_RETIRE_CFG |=> csr_hit) else $error("retire cfg miss");
  AST_HI_MISS: assert property (XLEN == 64 && csr_addr == CSR_CYCLE_CFG_H |=> !csr_hit) else $error("high hit");
  AST_OF_ZERO: assert property (csr_hit |-> csr_rdata[63] == 1'b0) else $error("bit 63 set");
  AST_CYC_HOLD: assert property (inh(cyc_q, cur_mode) && !cw |=> $stable(cycle_count)) else $error("cycle moved");
  AST_CYC_RUN: assert property (!inh(cyc_q, cur_mode) && !cw |=> cycle_count == $past(cycle_count) + 64'h1)
    else $error("cycle stuck");
  AST_RET_HOLD: assert property (retire_valid && !rw && (retire_exception || inh(ret_q, retire_mode)) |=>
    $stable(retire_count)) else $error("retire moved");
  AST_RET_RUN: assert property (retire_valid && !rw && !retire_exception && !inh(ret_q, retire_mode) |=>
    retire_count == $past(retire_count) + 64'h1) else $error("retire stuck");
  AST_RD_DATA: assert property (s_ret_wr ##1 s_ret_rd |=> csr_rdata[62:58] == $past(csr_wdata[62:58], 2))
    else $error("cfg readback");
endmodule : pmcf_filter_props
bind pmcf_filter pmcf_filter_props #(
  .XLEN (XLEN)
) u_props (
  .clk              (clk),
  .nrst             (nrst),
  .csr_we           (csr_we),
  .csr_addr         (csr_addr),
  .csr_wdata        (csr_wdata),
  .csr_rdata        (csr_rdata),
  .csr_hit          (csr_hit),
  .cur_mode         (cur_mode),
  .retire_valid     (retire_valid),
  .retire_exception (retire_exception),
  .retire_mode      (retire_mode),
  .cnt_we_cycle_lo  (cnt_we_cycle_lo),
  .cnt_we_cycle_hi  (cnt_we_cycle_hi),
  .cnt_we_retire_lo (cnt_we_retire_lo),
  .cnt_we_retire_hi (cnt_we_retire_hi),
  .cycle_count      (cycle_count),
  .retire_count     (retire_count)
);

// ### tb/pmcf_filter_tb_top.sv
`timescale 1ns/1ps
module pmcf_filter_tb_top;
  import pmcf_pkg::*;
  logic          clk, nrst, csr_we, csr_hit;
  logic [11:0]   csr_addr;
  logic [63:0]   csr_wdata, csr_rdata, cycle_count, retire_count, c0, r0, cfg;
  pmcf_mode_type cur_mode, retire_mode;
  logic          retire_valid, retire_exception;
  logic [3:0]    cnt_we;
  logic [31:0]   cnt_wd;
  int            errors, cmp_count;
  int            inh_bit [5] = '{USER_INH_BIT, SUPERVISOR_INH_BIT, MACHINE_INH_BIT,
                                 VIRT_SUPER_INH_BIT, VIRT_USER_INH_BIT};
  pmcf_filter uut (.clk(clk), .nrst(nrst), .csr_we(csr_we), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_hit(csr_hit), .cur_mode(cur_mode),
    .retire_valid(retire_valid), .retire_exception(retire_exception), .retire_mode(retire_mode),
    .cnt_we_cycle_lo(cnt_we[0]), .cnt_we_cycle_hi(cnt_we[1]), .cnt_we_retire_lo(cnt_we[2]),
    .cnt_we_retire_hi(cnt_we[3]), .cnt_wdata(cnt_wd), .cycle_count(cycle_count), .retire_count(retire_count));
  pmcf_hart_model hart (.clk(clk), .cur_mode(cur_mode), .retire_valid(retire_valid),
    .retire_exception(retire_exception), .retire_mode(retire_mode));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task cmp(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task csr_wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge clk);
    csr_we <= 1'b1;
    csr_addr <= a;
    csr_wdata <= d;
    @(posedge clk);
    csr_we <= 1'b0;
    csr_wdata <= ~d;
  endtask : csr_wr
  task csr_rd(input logic [11:0] a, input logic [63:0] exp, input logic hit);
    @(posedge clk);
    csr_addr <= a;
    @(posedge clk);
    @(negedge clk);
    cmp(csr_rdata, exp);
    cmp({63'h0, csr_hit}, {63'h0, hit});
  endtask : csr_rd
  // Eight cycles measured, one instruction retired in mode rm
  task window(input pmcf_mode_type m, input pmcf_mode_type rm, input logic e,
              input logic [63:0] cyc, input logic [63:0] ret);
    hart.go(m);
    repeat (2) @(posedge clk);
    @(negedge clk);
    c0 = cycle_count;
    r0 = retire_count;
    hart.retire(rm, e);
    repeat (6) @(posedge clk);
    @(negedge clk);
    cmp(cycle_count - c0, cyc);
    cmp(retire_count - r0, ret);
  endtask : window
  task set_cfg(input logic [63:0] d);
    csr_wr(CSR_CYCLE_CFG, d);
    csr_wr(CSR_RETIRE_CFG, d);
  endtask : set_cfg
  // Bit 0 cycle low, 1 cycle high, 2 retire low, 3 retire high
  task cnt_ld(input logic [3:0] sel, input logic [31:0] d);
    @(posedge clk);
    cnt_we <= sel;
    cnt_wd <= d;
    @(posedge clk);
    cnt_we <= 4'h0;
  endtask : cnt_ld
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  initial
  begin
    nrst = 1'b0;
    csr_we = 1'b0;
    csr_addr = 12'h000;
    csr_wdata = 64'h0;
    cnt_we = 4'h0;
    cnt_wd = 32'h0;
    errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    csr_rd(CSR_CYCLE_CFG, CFG_RESET, 1'b1);
    csr_rd(CSR_RETIRE_CFG, CFG_RESET, 1'b1);
    csr_wr(CSR_CYCLE_CFG, 64'hFFFF_FFFF_FFFF_FFFF);
    csr_rd(CSR_CYCLE_CFG, 64'h7FFF_FFFF_FFFF_FFFF, 1'b1);
    csr_wr(CSR_RETIRE_CFG, 64'h8000_0000_0000_1234);
    csr_rd(CSR_RETIRE_CFG, 64'h0000_0000_0000_1234, 1'b1);
    csr_rd(CSR_CYCLE_CFG_H, 64'h0, 1'b0);
    set_cfg(CFG_RESET);
    window(PMCF_MODE_USER, PMCF_MODE_USER, 1'b0, 64'h8, 64'h1);
    window(PMCF_MODE_MACHINE, PMCF_MODE_MACHINE, 1'b1, 64'h8, 64'h0);
    for (int i = 0; i < 5; i++)
    begin
      cfg = 64'h1 << inh_bit[i];
      set_cfg(cfg);
      window(pmcf_mode_type'(i), pmcf_mode_type'(i), 1'b0, 64'h0, 64'h0);
      window(pmcf_mode_type'((i + 1) % 5), pmcf_mode_type'((i + 1) % 5), 1'b0, 64'h8, 64'h1);
    end
    set_cfg(64'h1 << MACHINE_INH_BIT);
    window(PMCF_MODE_USER, PMCF_MODE_MACHINE, 1'b0, 64'h8, 64'h0);
    set_cfg(64'h7C00_0000_0000_0000);
    cnt_ld(4'h1, 32'h1234_5678);
    cnt_ld(4'h2, 32'h0000_00AB);
    cnt_ld(4'h4, 32'hA5A5_0001);
    cnt_ld(4'h8, 32'h0000_0002);
    @(negedge clk);
    cmp(cycle_count, 64'h0000_00AB_1234_5678);
    cmp(retire_count, 64'h0000_0002_A5A5_0001);
    window(PMCF_MODE_VIRT_USER, PMCF_MODE_SUPERVISOR, 1'b0, 64'h0, 64'h0);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp(cycle_count, COUNT_RESET);
    cmp(retire_count, COUNT_RESET);
    @(posedge clk);
    nrst <= 1'b1;
    csr_rd(CSR_CYCLE_CFG, CFG_RESET, 1'b1);
    finish_test;
  end
endmodule : pmcf_filter_tb_top

// ### tb/pmcf_hart_model.sv
`timescale 1ns/1ps
module pmcf_hart_model
  import pmcf_pkg::*;
(
  // Clock
  input wire logic              clk,
  // Pipeline outputs
  output pmcf_pkg::pmcf_mode_type cur_mode,
  output logic                  retire_valid,
  output logic                  retire_exception,
  output pmcf_pkg::pmcf_mode_type retire_mode
);
  initial
  begin
    cur_mode = PMCF_MODE_MACHINE;
    retire_mode = PMCF_MODE_MACHINE;
    retire_valid = 1'b0;
    retire_exception = 1'b0;
  end
  // Mode changes land in one cycle here
  task go(input pmcf_mode_type m);
    @(posedge clk);
    cur_mode <= m;
  endtask : go
  task retire(input pmcf_mode_type m, input logic e);
    @(posedge clk);
    retire_valid <= 1'b1;
    retire_mode <= m;
    retire_exception <= e;
    @(posedge clk);
    retire_valid <= 1'b0;
    retire_exception <= ~e;
  endtask : retire
endmodule : pmcf_hart_model
